// >>> rtl/mpf_pin_ctrl.sv
// pin function, direction and pull-up logic for ports 0 to 10
// Notes on behaviour
// - each multifunction pin picks port or alternate function on its own
// - port zero has seven I/O bits, direction set per bit
// - per-bit pull-ups on ports 0,2,3,7,8,10 apply in both directions
// - seven interrupt inputs detect rising, falling or both edges
// - separate rising and falling enable registers; both set means both edges
// - valid edge on interrupt input two also triggers the real-time output port
// - non-maskable request on the shared pin uses the same edge enables
// - port one is an eight-bit input-only port, no pull-ups, analog capable
// - analog-assigned port-one bits read undefined; here they read zero
// - bus variant: open-drain control for pins 25 to 27
// - port four group pull-up by bit four, port-mode inputs only
// - expansion mode: port four is the address/data byte, group pull-up kept
// - port five group pull-up by bit five; expansion carries address 8 to 15
// - port six group pull-up by bit six, inputs and expansion mode
// - expansion: port six low nibble high address, bits 4, 5 and 7 bus strobes, bit 6 the wait pin
// - without wait insertion the wait pin stays a general I/O bit
// - port seven: three I/O bits with serial alternate functions
// - falling edge on port eight sets the key-return flag
// - expansion: port eight drives low address, per-bit pull-ups
// - port nine: six open-drain bits, no pull-ups, no alternate function
// - port ten: four bits, timer clock inputs and timer outputs
// - port three routes capture trigger and sixteen-bit timer clock
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none
module mpf_pin_ctrl #(
    parameter bit BUS_VARIANT = 1'b1
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [mpf_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [10:0][7:0] pin_in,
    output logic [10:0][7:0] pin_out,
    output logic [10:0][7:0] pin_oe_n,
    output logic [10:0][7:0] pin_pu,
    output logic [6:0] ext_irq_inputs,
    output logic ext_irq_two_rtp_trigger,
    output logic nmi_req,
    output logic key_return_irq_flag,
    output logic [7:0] analog_input_pins,
    input wire logic [7:0] low_addr_data_bus_wr,
    input wire logic low_addr_data_bus_drv,
    output logic [7:0] low_addr_data_bus_rd,
    input wire logic [7:0] mid_address_bus,
    input wire logic [3:0] high_address_bus,
    input wire logic [7:0] low_address_bus,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic address_latch_strobe,
    output logic wait_request,
    input wire logic [7:0] p2_alt_out,
    input wire logic [7:0] p2_alt_drv,
    output logic [7:0] p2_alt_in,
    input wire logic [7:0] p3_alt_out,
    input wire logic [7:0] p3_alt_drv,
    output logic [7:0] p3_alt_in,
    output logic capture_trigger_in,
    output logic timer16_ext_clock_in,
    input wire logic [2:0] p7_alt_out,
    input wire logic [2:0] p7_alt_drv,
    output logic [2:0] p7_alt_in,
    output logic serial_clock_pin_two,
    output logic baud_clock_pin_two,
    input wire logic [3:0] timer8_outputs,
    input wire logic [3:0] timer8_out_drv,
    output logic [3:0] timer8_ext_clock_inputs
);
    import mpf_pkg::*;

    logic [NUM_PORTS-1:0][7:0] latch_reg;
    logic [NUM_PORTS-1:0][7:0] mode_reg;
    logic [NUM_PORTS-1:0][7:0] ctrl_reg;
    logic [NUM_PORTS-1:0][7:0] pull_reg;
    logic [7:0] grp_pull_reg;
    logic [6:0] rise_en_reg;
    logic [6:0] fall_en_reg;
    logic [1:0] exp_ctrl_reg;
    logic [7:0] od_ctrl_reg;
    logic [10:0][7:0] pin_smp_reg;
    logic [10:0][7:0] out_next;
    logic [10:0][7:0] oe_n_next;
    logic [10:0][7:0] pu_next;
    logic [6:0] irq_edge;
    logic [7:0] key_edge;
    logic exp_en;
    logic wait_en;
    logic wr_fire;
    logic rd_hit;
    logic [31:0] rd_word;

    assign exp_en = exp_ctrl_reg[EXP_EN_BIT];
    assign wait_en = exp_ctrl_reg[WAIT_EN_BIT];
    assign wr_fire = psel && penable && pready && pwrite;

    // address decode: true when addr names a bank word of a real port
    function automatic logic bank_hit(input logic [11:0] a, input logic [11:0] base);
        logic [11:0] off;
        off = a - base;
        bank_hit = (a >= base) && (off[11:6] == 6'h00) && (off[1:0] == 2'b00) && (off[5:2] < 4'd11);
    endfunction

    // port index carried by a bank address
    function automatic int bank_idx(input logic [11:0] a);
        bank_idx = int'(a[5:2]);
    endfunction

    // read value of a data register
    function automatic logic [7:0] port_read(input int n, input logic [7:0] latch,
                                             input logic [7:0] mode, input logic [7:0] ctrl,
                                             input logic [7:0] smp);
        logic [7:0] v;
        v = (~mode & ~ctrl & latch) | ((mode | ctrl) & smp);
        if (n == 1)
            v = smp & ~ctrl;
        port_read = v & mpf_port_mask(n);
    endfunction

    // sample pins once per clock
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pin_smp_reg <= '0;
        else
            pin_smp_reg <= pin_in;
    end

    // per-port register banks
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int n = 0; n < NUM_PORTS; n++)
            begin
                latch_reg[n] <= DATA_RST;
                mode_reg[n] <= MODE_RST;
                ctrl_reg[n] <= CTRL_RST;
                pull_reg[n] <= PULL_RST;
            end
        end
        else if (wr_fire)
        begin
            if (bank_hit(paddr, CTRL_BASE))
                ctrl_reg[bank_idx(paddr - CTRL_BASE)] <= pwdata[7:0] & mpf_port_mask(bank_idx(paddr - CTRL_BASE));
            if (bank_hit(paddr, MODE_BASE))
                mode_reg[bank_idx(paddr - MODE_BASE)] <= pwdata[7:0] | ~mpf_port_mask(bank_idx(paddr - MODE_BASE));
            if (bank_hit(paddr, DATA_BASE))
                latch_reg[bank_idx(paddr - DATA_BASE)] <= pwdata[7:0] & mpf_port_mask(bank_idx(paddr - DATA_BASE));
            if (bank_hit(paddr, PULL_BASE) && mpf_bit_pull(bank_idx(paddr - PULL_BASE)))
                pull_reg[bank_idx(paddr - PULL_BASE)] <= pwdata[7:0] & mpf_port_mask(bank_idx(paddr - PULL_BASE));
        end
    end

    // shared option and mode registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            grp_pull_reg <= 8'h00;
            rise_en_reg <= 7'h00;
            fall_en_reg <= 7'h00;
            exp_ctrl_reg <= 2'h0;
            od_ctrl_reg <= 8'h00;
        end
        else if (wr_fire)
        begin
            if (paddr == GRP_PULL_ADDR)
                grp_pull_reg <= pwdata[7:0];
            if (paddr == RISE_EN_ADDR)
                rise_en_reg <= pwdata[6:0];
            if (paddr == FALL_EN_ADDR)
                fall_en_reg <= pwdata[6:0];
            if (paddr == EXP_CTRL_ADDR)
                exp_ctrl_reg <= pwdata[1:0];
            if (paddr == OD_CTRL_ADDR && BUS_VARIANT)
                od_ctrl_reg <= {pwdata[OD_HI:OD_LO], 5'h00};
        end
    end

    // interrupt input edges on port zero
    // programmable edge
    mpf_edge_det #(.W(7)) u_irq_edge (
        .pclk(pclk),
        .presetn(presetn),
        .sig(pin_smp_reg[0][6:0]),
        .rise_en(rise_en_reg),
        .fall_en(fall_en_reg),
        .edge_pulse(irq_edge)
    );

    // key-return falling edges on port eight
    mpf_edge_det #(.W(8)) u_key_edge (
        .pclk(pclk),
        .presetn(presetn),
        .sig(pin_smp_reg[8]),
        .rise_en(8'h00),
        .fall_en(8'hFF),
        .edge_pulse(key_edge)
    );

    // interrupt requests to the controller
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ext_irq_inputs <= 7'h00;
            ext_irq_two_rtp_trigger <= 1'b0;
            nmi_req <= 1'b0;
        end
        else
        begin
            ext_irq_inputs <= irq_edge & ctrl_reg[0][6:0];
            ext_irq_two_rtp_trigger <= irq_edge[NMI_BIT] & ctrl_reg[0][NMI_BIT];
            nmi_req <= irq_edge[NMI_BIT];
        end
    end

    // key-return flag, set wins over clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            key_return_irq_flag <= 1'b0;
        else if (|key_edge)
            key_return_irq_flag <= 1'b1;
        else if (wr_fire && paddr == KEY_FLAG_ADDR && pwdata[0])
            key_return_irq_flag <= 1'b0;
    end

    // pin drive, level and pull-up selection
    always_comb
    begin
        for (int n = 0; n < NUM_PORTS; n++)
        begin
            out_next[n] = latch_reg[n];
            oe_n_next[n] = mode_reg[n] | ctrl_reg[n] | ~mpf_port_mask(n);
            pu_next[n] = mpf_bit_pull(n) ? pull_reg[n] : 8'h00;
        end
        oe_n_next[1] = 8'hFF;
        pu_next[1] = 8'h00;
        for (int b = 0; b < 8; b++)
        begin
            if (ctrl_reg[2][b])
            begin
                out_next[2][b] = p2_alt_out[b];
                oe_n_next[2][b] = ~p2_alt_drv[b];
            end
            if (ctrl_reg[3][b])
            begin
                out_next[3][b] = p3_alt_out[b];
                oe_n_next[3][b] = ~p3_alt_drv[b];
            end
        end
        for (int b = 0; b < 3; b++)
        begin
            if (ctrl_reg[7][b])
            begin
                out_next[7][b] = p7_alt_out[b];
                oe_n_next[7][b] = ~p7_alt_drv[b];
            end
        end
        for (int b = 0; b < 4; b++)
        begin
            if (ctrl_reg[10][b])
            begin
                out_next[10][b] = timer8_outputs[b];
                oe_n_next[10][b] = ~timer8_out_drv[b];
            end
        end
        for (int b = OD_LO; b <= OD_HI; b++)
        begin
            if (od_ctrl_reg[b] && out_next[2][b])
                oe_n_next[2][b] = 1'b1;
        end
        pu_next[4] = {8{grp_pull_reg[GRP_PU_P4]}} & mode_reg[4] & ~ctrl_reg[4];
        pu_next[5] = {8{grp_pull_reg[GRP_PU_P5]}} & (mode_reg[5] | ctrl_reg[5]) & ~(ctrl_reg[5] & {8{~exp_en}});
        pu_next[6] = {8{grp_pull_reg[GRP_PU_P6]}} & (mode_reg[6] | (ctrl_reg[6] & {8{exp_en}}));
        if (exp_en)
        begin
            for (int b = 0; b < 8; b++)
            begin
                if (ctrl_reg[4][b])
                begin
                    out_next[4][b] = low_addr_data_bus_wr[b];
                    oe_n_next[4][b] = ~low_addr_data_bus_drv;
                    pu_next[4][b] = grp_pull_reg[GRP_PU_P4];
                end
                if (ctrl_reg[5][b])
                begin
                    out_next[5][b] = mid_address_bus[b];
                    oe_n_next[5][b] = 1'b0;
                end
                if (ctrl_reg[8][b])
                begin
                    out_next[8][b] = low_address_bus[b];
                    oe_n_next[8][b] = 1'b0;
                end
            end
            for (int b = 0; b < 4; b++)
            begin
                if (ctrl_reg[6][b])
                begin
                    out_next[6][b] = high_address_bus[b];
                    oe_n_next[6][b] = 1'b0;
                end
            end
            if (ctrl_reg[6][P6_RD])
            begin
                out_next[6][P6_RD] = read_strobe_n;
                oe_n_next[6][P6_RD] = 1'b0;
            end
            if (ctrl_reg[6][P6_WR])
            begin
                out_next[6][P6_WR] = write_strobe_n;
                oe_n_next[6][P6_WR] = 1'b0;
            end
            if (ctrl_reg[6][P6_ADDRESS_LATCH_STROBE])
            begin
                out_next[6][P6_ADDRESS_LATCH_STROBE] = address_latch_strobe;
                oe_n_next[6][P6_ADDRESS_LATCH_STROBE] = 1'b0;
            end
        end
        // wait pin is general I/O unless expansion and waits are both on
        if (!(exp_en && wait_en))
            oe_n_next[6][P6_WAIT] = mode_reg[6][P6_WAIT];
        else
            oe_n_next[6][P6_WAIT] = 1'b1;
        // control bits of ports 4,5,8 and of port 6 except the wait pin act as inputs without expansion
        if (!exp_en)
        begin
            oe_n_next[4] = oe_n_next[4] | ctrl_reg[4];
            oe_n_next[8] = oe_n_next[8] | ctrl_reg[8];
        end
        for (int b = 0; b < 8; b++)
        begin
            if (latch_reg[9][b])
                oe_n_next[9][b] = 1'b1;
        end
        out_next[9] = 8'h00;
        pu_next[9] = 8'h00;
    end

    // registered pin outputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_out <= '0;
            pin_oe_n <= '1;
            pin_pu <= '0;
        end
        else
        begin
            pin_out <= out_next;
            pin_oe_n <= oe_n_next;
            pin_pu <= pu_next;
        end
    end

    // alternate-function inputs toward peripherals
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            analog_input_pins <= 8'h00;
            low_addr_data_bus_rd <= 8'h00;
            wait_request <= 1'b0;
            p2_alt_in <= 8'h00;
            p3_alt_in <= 8'h00;
            capture_trigger_in <= 1'b0;
            timer16_ext_clock_in <= 1'b0;
            p7_alt_in <= 3'h0;
            serial_clock_pin_two <= 1'b0;
            baud_clock_pin_two <= 1'b0;
            timer8_ext_clock_inputs <= 4'h0;
        end
        else
        begin
            analog_input_pins <= ctrl_reg[1];
            low_addr_data_bus_rd <= pin_smp_reg[4];
            wait_request <= exp_en && wait_en && !pin_smp_reg[6][P6_WAIT];
            p2_alt_in <= pin_smp_reg[2] & ctrl_reg[2];
            p3_alt_in <= pin_smp_reg[3] & ctrl_reg[3];
            capture_trigger_in <= pin_smp_reg[3][P3_CAPTURE] & ctrl_reg[3][P3_CAPTURE];
            timer16_ext_clock_in <= pin_smp_reg[3][P3_T16_CLK] & ctrl_reg[3][P3_T16_CLK];
            p7_alt_in <= pin_smp_reg[7][2:0] & ctrl_reg[7][2:0];
            serial_clock_pin_two <= pin_smp_reg[7][P7_SCLK] & ctrl_reg[7][P7_SCLK];
            baud_clock_pin_two <= pin_smp_reg[7][P7_SCLK] & ctrl_reg[7][P7_SCLK];
            timer8_ext_clock_inputs <= pin_smp_reg[10][3:0] & ctrl_reg[10][3:0];
        end
    end

    // read mux
    always_comb
    begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b1;
        if (bank_hit(paddr, DATA_BASE))
            rd_word[7:0] = port_read(bank_idx(paddr), latch_reg[bank_idx(paddr)], mode_reg[bank_idx(paddr)],
                                     ctrl_reg[bank_idx(paddr)], pin_smp_reg[bank_idx(paddr)]);
        else if (bank_hit(paddr, MODE_BASE))
            rd_word[7:0] = mode_reg[bank_idx(paddr - MODE_BASE)] & mpf_port_mask(bank_idx(paddr - MODE_BASE));
        else if (bank_hit(paddr, CTRL_BASE))
            rd_word[7:0] = ctrl_reg[bank_idx(paddr - CTRL_BASE)];
        else if (bank_hit(paddr, PULL_BASE))
            rd_word[7:0] = pull_reg[bank_idx(paddr - PULL_BASE)];
        else if (paddr == GRP_PULL_ADDR)
            rd_word[7:0] = grp_pull_reg;
        else if (paddr == RISE_EN_ADDR)
            rd_word[6:0] = rise_en_reg;
        else if (paddr == FALL_EN_ADDR)
            rd_word[6:0] = fall_en_reg;
        else if (paddr == EXP_CTRL_ADDR)
            rd_word[1:0] = exp_ctrl_reg;
        else if (paddr == OD_CTRL_ADDR)
            rd_word[7:0] = od_ctrl_reg;
        else if (paddr == KEY_FLAG_ADDR)
            rd_word[0] = key_return_irq_flag;
        else
            rd_hit = 1'b0;
    end

    // apb slave: one wait state, answer registered
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (psel && penable && !pready)
        begin
            pready <= 1'b1;
            prdata <= pwrite ? 32'h0000_0000 : rd_word;
            pslverr <= !rd_hit;
        end
        else
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end
endmodule // mpf_pin_ctrl
`default_nettype wire

// >>> include/mpf_pkg.sv
// constants and helpers for the multi-port pin function block
package mpf_pkg;
    localparam int NUM_PORTS = 11;
    localparam int ADDR_W = 12;
    // register bank bases, one word per port index
    localparam logic [11:0] DATA_BASE = 12'h000;
    localparam logic [11:0] MODE_BASE = 12'h040;
    localparam logic [11:0] CTRL_BASE = 12'h080;
    localparam logic [11:0] PULL_BASE = 12'h0C0;
    // single registers
    localparam logic [11:0] GRP_PULL_ADDR = 12'h100;
    localparam logic [11:0] RISE_EN_ADDR = 12'h104;
    localparam logic [11:0] FALL_EN_ADDR = 12'h108;
    localparam logic [11:0] EXP_CTRL_ADDR = 12'h10C;
    localparam logic [11:0] OD_CTRL_ADDR = 12'h110;
    localparam logic [11:0] KEY_FLAG_ADDR = 12'h114;
    // reset values: every bit an input in port mode
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [7:0] MODE_RST = 8'hFF;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] PULL_RST = 8'h00;
    // group pull-up bit positions
    localparam int GRP_PU_P4 = 4;
    localparam int GRP_PU_P5 = 5;
    localparam int GRP_PU_P6 = 6;
    // expansion control bit positions
    localparam int EXP_EN_BIT = 0;
    localparam int WAIT_EN_BIT = 1;
    // open-drain pins of port two
    localparam int OD_LO = 5;
    localparam int OD_HI = 7;
    // port six control pins
    localparam int P6_RD = 4;
    localparam int P6_WR = 5;
    localparam int P6_WAIT = 6;
    localparam int P6_ADDRESS_LATCH_STROBE = 7;
    // port three timer input pins, port seven serial clock pin, port zero nmi bit
    localparam int P3_T16_CLK = 5;
    localparam int P3_CAPTURE = 6;
    localparam int P7_SCLK = 2;
    localparam int NMI_BIT = 2;
    // implemented bits of each port
    function automatic logic [7:0] mpf_port_mask(input int n);
        case (n)
            0: mpf_port_mask = 8'h7F;
            7: mpf_port_mask = 8'h07;
            9: mpf_port_mask = 8'h3F;
            10: mpf_port_mask = 8'h0F;
            default: mpf_port_mask = 8'hFF;
        endcase
    endfunction
    // ports whose pull-ups are set bit by bit
    function automatic logic mpf_bit_pull(input int n);
        mpf_bit_pull = (n == 0) || (n == 2) || (n == 3) || (n == 7) || (n == 8) || (n == 10);
    endfunction
endpackage

// >>> rtl/mpf_edge_det.sv
// per-bit programmable edge detector
`timescale 1ns/10ps
`default_nettype none
module mpf_edge_det #(
    parameter int W = 7
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] sig,
    input wire logic [W-1:0] rise_en,
    input wire logic [W-1:0] fall_en,
    output logic [W-1:0] edge_pulse
);
    logic [W-1:0] prev_reg;

    // remember last level
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prev_reg <= '0;
        else
            prev_reg <= sig;
    end

    // one-cycle pulse on each enabled edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            edge_pulse <= '0;
        else
            edge_pulse <= (rise_en & sig & ~prev_reg) | (fall_en & ~sig & prev_reg);
    end
endmodule // mpf_edge_det
`default_nettype wire

// >>> verification/mpf_pin_ctrl_asserts.sv
// port-level assertions for the pin function block
`timescale 1ns/10ps
`default_nettype none
module mpf_pin_ctrl_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [mpf_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic [10:0][7:0] pin_in,
    input wire logic [10:0][7:0] pin_oe_n,
    input wire logic [10:0][7:0] pin_pu,
    input wire logic [6:0] ext_irq_inputs,
    input wire logic ext_irq_two_rtp_trigger,
    input wire logic nmi_req,
    input wire logic key_return_irq_flag
);
    import mpf_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // one wait state, then a single ready pulse
    a_ready_wait_state: assert property (psel && penable && !pready |=> pready ##1 !pready)
        else $error("ready not one wait state");
    a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_port1_input: assert property (pin_oe_n[1] == 8'hFF && pin_pu[1] == 8'h00)
        else $error("port one driven or pulled");
    a_port9_no_pull: assert property (pin_pu[9] == 8'h00)
        else $error("port nine pulled up");
    a_rtp_is_irq2: assert property (ext_irq_two_rtp_trigger == ext_irq_inputs[2])
        else $error("trigger differs from irq two");
    a_irq2_has_edge: assert property (ext_irq_inputs[2] |-> $past(pin_in[0][2], 3) != $past(pin_in[0][2], 4))
        else $error("irq two without pin edge");
    a_nmi_has_edge: assert property (nmi_req |-> $past(pin_in[0][2], 3) != $past(pin_in[0][2], 4))
        else $error("nmi without pin edge");
    a_key_sets: assert property ($fell(pin_in[8][0]) |-> ##[1:4] key_return_irq_flag)
        else $error("key flag not set");
    a_key_holds: assert property ($fell(key_return_irq_flag) |-> $past(psel && pwrite && paddr == KEY_FLAG_ADDR))
        else $error("key flag lost");
    c_irq2: cover property (ext_irq_inputs[2] && nmi_req);
    c_key: cover property ($rose(key_return_irq_flag));
    c_port3_out: cover property (pin_oe_n[3] == 8'h00);
endmodule // mpf_pin_ctrl_asserts
`default_nettype wire

// >>> verification/mpf_pin_model.sv
// outside world of the pins: drivers meet the block's outputs
`timescale 1ns/10ps
`default_nettype none
module mpf_pin_model (
    input wire logic [10:0][7:0] pin_out,
    input wire logic [10:0][7:0] pin_oe_n,
    input wire logic [10:0][7:0] ext,
    output logic [10:0][7:0] pin_in
);
    // driven bits show the block's value, released bits the outside source
    assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext);
endmodule // mpf_pin_model
`default_nettype wire

// >>> verification/mpf_pin_ctrl_tb_top.sv
// testbench for the pin function block
`timescale 1ns/10ps
`default_nettype none
module mpf_pin_ctrl_tb_top;
    import mpf_pkg::*;
    typedef struct packed {logic w; logic [11:0] a; logic [7:0] d; logic [7:0] x; logic e;} mpf_row_t;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr, e;
    logic [ADDR_W-1:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic [10:0][7:0] pin_in, pin_out, pin_oe_n, pin_pu, ext;
    logic [7:0] alt = 8'h5A, analog_input_pins, low_addr_data_bus_rd, p2_alt_in, p3_alt_in;
    logic [6:0] ext_irq_inputs;
    logic [3:0] timer8_ext_clock_inputs;
    logic [2:0] p7_alt_in;
    logic ext_irq_two_rtp_trigger, nmi_req, key_return_irq_flag, wait_request, capture_trigger_in;
    logic timer16_ext_clock_in, serial_clock_pin_two, baud_clock_pin_two;
    // bus unit and peripheral sides all follow one pattern
    wire logic [7:0] low_addr_data_bus_wr = alt, mid_address_bus = ~alt, low_address_bus = alt;
    wire logic [7:0] p2_alt_out = alt, p2_alt_drv = ~alt, p3_alt_out = ~alt, p3_alt_drv = alt;
    wire logic [3:0] high_address_bus = alt[3:0], timer8_outputs = alt[7:4], timer8_out_drv = alt[3:0];
    wire logic [2:0] p7_alt_out = alt[2:0], p7_alt_drv = alt[5:3];
    wire logic low_addr_data_bus_drv = alt[0], read_strobe_n = alt[1], write_strobe_n = alt[2];
    wire logic address_latch_strobe = alt[3];
    int error_cnt = 0, num_checks = 0, cyc = 0, hits;
    mpf_row_t rows [17];
    always #20 pclk = ~pclk;
    mpf_pin_ctrl DUT (.*);
    mpf_pin_model PINS (.*);
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic print_verdict();
        $display("errors=%0d checks=%0d", error_cnt, num_checks);
        if (error_cnt == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // hang guard
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            error_cnt++;
            print_verdict();
        end
    end
    initial
    begin
        ext = {11{8'hFF}};
        ext[0] = 8'h00;
        rows = '{'{1'h1, MODE_BASE + 12'h00C, 8'h00, 8'h00, 1'h0},
            '{1'h1, DATA_BASE + 12'h00C, 8'hA5, 8'h00, 1'h0},
            '{1'h0, DATA_BASE + 12'h00C, 8'h00, 8'hA5, 1'h0},
            '{1'h1, PULL_BASE + 12'h00C, 8'h3C, 8'h00, 1'h0},
            '{1'h0, PULL_BASE + 12'h00C, 8'h00, 8'h3C, 1'h0},
            '{1'h0, 12'h200, 8'h00, 8'h00, 1'h1},
            '{1'h1, RISE_EN_ADDR, 8'h04, 8'h00, 1'h0},
            '{1'h1, FALL_EN_ADDR, 8'h04, 8'h00, 1'h0},
            '{1'h1, CTRL_BASE, 8'h07, 8'h00, 1'h0},
            '{1'h1, GRP_PULL_ADDR, 8'h10, 8'h00, 1'h0},
            '{1'h1, CTRL_BASE + 12'h014, 8'hFF, 8'h00, 1'h0},
            '{1'h1, CTRL_BASE + 12'h004, 8'h0F, 8'h00, 1'h0},
            '{1'h0, DATA_BASE + 12'h004, 8'h00, 8'hF0, 1'h0},
            '{1'h1, CTRL_BASE + 12'h028, 8'h0F, 8'h00, 1'h0},
            '{1'h1, MODE_BASE + 12'h024, 8'h00, 8'h00, 1'h0},
            '{1'h1, DATA_BASE + 12'h024, 8'h05, 8'h00, 1'h0},
            '{1'h1, EXP_CTRL_ADDR, 8'h01, 8'h00, 1'h0}};
        repeat (5) @(posedge pclk);
        presetn <= 1'h1;
        chk(pin_oe_n[3], 8'hFF);
        foreach (rows[i])
        begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w)
            begin
                chk(r[7:0], rows[i].x);
                chk({7'h0, e}, {7'h0, rows[i].e});
            end
        end
        repeat (2) @(posedge pclk);
        chk(pin_out[3], 8'hA5);
        chk(pin_oe_n[3], 8'h00);
        chk(pin_pu[3], 8'h3C);
        chk(pin_pu[4], 8'hFF);
        chk(pin_out[5], ~alt);
        chk(pin_oe_n[5], 8'h00);
        chk(analog_input_pins, 8'h0F);
        chk(pin_out[10], 8'h05);
        chk(pin_oe_n[10], 8'hF5);
        chk({4'h0, timer8_ext_clock_inputs}, 8'h05);
        chk(pin_oe_n[9], 8'hC5);
        chk(pin_out[9], 8'h00);
        // rise and fall each give one pulse, then rising edges are switched off
        for (int i = 0; i < 3; i++)
        begin
            if (i == 2)
                apb(1'h1, RISE_EN_ADDR, 8'h00);
            ext[0][2] <= ~ext[0][2];
            hits = 0;
            repeat (6)
            begin
                @(posedge pclk);
                hits += int'(ext_irq_inputs[2] === 1'h1 && nmi_req === 1'h1);
            end
            chk(8'(hits), (i == 2) ? 8'h00 : 8'h01);
        end
        ext[8][0] <= 1'h0;
        repeat (5) @(posedge pclk);
        chk({7'h0, key_return_irq_flag}, 8'h01);
        apb(1'h1, KEY_FLAG_ADDR, 8'h01);
        apb(1'h0, KEY_FLAG_ADDR, 8'h00);
        chk(r[7:0], 8'h00);
        presetn <= 1'h0;
        repeat (2) @(posedge pclk);
        chk(pin_oe_n[3], 8'hFF);
        chk(pin_pu[3], 8'h00);
        print_verdict();
    end
endmodule // mpf_pin_ctrl_tb_top
bind mpf_pin_ctrl mpf_pin_ctrl_asserts CHK (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
    .pin_in, .pin_oe_n, .pin_pu, .ext_irq_inputs, .ext_irq_two_rtp_trigger, .nmi_req, .key_return_irq_flag);
`default_nettype wire
